// *** shared/vram_ctrl_consts.svh ***
// Register map, field positions and timing counts of the video DRAM controller
`ifndef VRAM_CTRL_CONSTS_SVH
`define VRAM_CTRL_CONSTS_SVH
`define ADR_CMD 8'h00
`define ADR_STATUS 8'h04
`define ADR_ROW 8'h08
`define ADR_COL 8'h0c
`define ADR_DATA 8'h10
`define ADR_MASK 8'h14
`define ADR_CTRL 8'h18
`define CTRL_REF_EN 0
`define CTRL_REF_CBR 1
`define CTRL_OPT_LO 2
`define CTRL_OPT_HI 3
`define CTRL_SC_EN 4
`define CBR_RESET 2'h0
`define CBR_PLAIN 2'h1
`define CBR_STOP 2'h2
`define CLK_NS 25
`define T_PHASE_NS 50
`define PHASE_CYC 3'((`T_PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_ROWREF_NS 15625
`define ROWREF_CYC 10'(`T_ROWREF_NS / `CLK_NS)
`define REF_SLACK_CYC 11'h040
`define SC_HALF_CYC 3'h2
`endif

// *** shared/vram_ctrl_pkg.sv ***
// Types shared by the video DRAM controller modules
package vram_ctrl_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_WRITE, OP_MWRITE, OP_BLOCK, OP_LMR, OP_LCR, OP_RT, OP_SRT,
    OP_HIDDEN, OP_REF_ROW, OP_REF_CBR
  } op_t;
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_RAS, S_COL, S_CAS, S_SYNC, S_HIDE, S_PRE
  } state_t;
  typedef struct packed {
    state_t state;
    logic [2:0] ph;
    op_t op;
    logic busy;
    logic full_done;
    logic refused;
    logic ref_act;
    logic pend;
    logic hide_dn;
    logic [8:0] row;
    logic [8:0] col;
    logic [8:0] ref_row;
    logic [15:0] data;
    logic [15:0] mask;
    logic [15:0] rd_data;
    logic [4:0] ctrl;
    logic [2:0] scdiv;
    logic sc;
    logic ras_n;
    logic cas_n;
    logic [8:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
    logic sfs;
    logic wme_n;
    logic dt_n;
    logic ack;
    logic [31:0] dat_o;
    logic [10:0] since_ref;
  } ctl_t;
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } tmr_t;
endpackage : vram_ctrl_pkg

// *** testbench/vram_dev_model.sv ***
// Pin-level behavioural model of the dual-port video DRAM
`timescale 1ns/100ps
module vram_dev_model (
  input wire logic row_strobe_n,
  input wire logic lower_byte_column_strobe_n,
  input wire logic upper_byte_column_strobe_n,
  input wire logic [8:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic special_function_select,
  input wire logic write_mask_enable_n,
  input wire logic transfer_output_enable_n,
  input wire logic serial_shift_clock,
  output logic [15:0] dq_in,
  output logic half_indicator
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] mask, mask_reg, colour, pm;
  logic [15:0] rd_val = 16'h0000;
  logic [8:0] row, xfer_row, ref_cnt = 9'h000, stop_reg = 9'h1ff, sptr = 9'h000;
  logic [7:0] tap;
  logic [8:0] stop_act = 9'h1ff; // Stop point in force; a new one waits for a split
  logic persist = 1'b0; // Per-cycle mask mode after power-up
  logic drv = 1'b0, pend = 1'b0, got_cas, wm0, sf0;
  logic [1:0] kind = 2'd0; // 0 ram, 1 full, 2 split, 3 counter refresh
  logic cas_n;
  int n_ref = 0, n_stop = 0, n_full = 0, n_split = 0, n_rowonly = 0;
  // Both column strobes move together on this controller
  assign cas_n = lower_byte_column_strobe_n & upper_byte_column_strobe_n;
  // Outside a read the lines show the inverse, so a stale value never passes
  assign dq_in = (drv && !transfer_output_enable_n && !cas_n) ? rd_val : ~rd_val;
  assign half_indicator = sptr[8];
  // Cycle type is fixed once, at the row strobe fall
  always @(negedge row_strobe_n) begin
    got_cas = 1'b0;
    wm0 = write_mask_enable_n;
    sf0 = special_function_select;
    if (!cas_n) begin
      kind = 2'd3;
      ref_cnt = ref_cnt + 9'd1;
      n_ref++;
      if (!sf0) begin
        persist = 1'b0;
        stop_reg = 9'h1ff;
        stop_act = 9'h1ff; // Option reset acts at once
      end else if (!wm0) begin
        stop_reg = addr;
        n_stop++;
      end // Otherwise refresh only
    end else begin
      row = addr;
      mask = persist ? mask_reg : dq_out;
      kind = transfer_output_enable_n ? 2'd0 : (sf0 ? 2'd2 : 2'd1);
    end
  end
  // A row cycle with no column strobe is a row-only refresh
  always @(posedge row_strobe_n) begin
    if (kind == 2'd0 && !got_cas) begin
      n_rowonly++;
      n_ref++;
    end
  end
  // Column strobe fall refines writes and takes column addresses
  always @(negedge cas_n) begin
    if (!row_strobe_n) begin
      got_cas = 1'b1;
      case (kind)
        2'd1: begin
          xfer_row = row;
          sptr = addr;
          n_full++;
        end
        2'd2: begin
          tap = addr[7:0];
          pend = 1'b1;
          stop_act = stop_reg;
          n_split++;
        end
        2'd0: if (sf0) begin
          if (special_function_select) colour = dq_out;
          else begin
            mask_reg = dq_out;
            persist = 1'b1;
          end
        end else if (!write_mask_enable_n) begin
          if (wm0) mask = 16'hffff;
          if (special_function_select) begin
            for (int i = 0; i < 8; i++) begin
              pm = mask & {{8{dq_out[8+i]}}, {8{dq_out[i]}}};
              mem[{row, addr[8:3], 3'(i)}] = (mem[{row, addr[8:3], 3'(i)}] & ~pm) | (colour & pm);
            end
          end else mem[{row, addr}] = (mem[{row, addr}] & ~mask) | (dq_out & mask);
        end else begin
          rd_val = mem[{row, addr}];
          drv = 1'b1;
        end
        default: ;
      endcase
    end
  end
  always @(posedge cas_n) drv = 1'b0;
  // Serial pointer; a pending split start is taken at the half boundary
  always @(posedge serial_shift_clock) begin
    if (sptr[7:0] == 8'hff && pend) begin
      sptr = {~sptr[8], tap};
      pend = 1'b0;
    end else sptr = sptr + 9'd1;
  end
endmodule : vram_dev_model

// *** testbench/vram_refresh_transfer_logic_tb.sv ***
// Self-checking bench: host controller driving the video DRAM model
`timescale 1ns/100ps
`include "vram_ctrl_consts.svh"
module vram_refresh_transfer_logic_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic write_mask_enable_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_ack_o, row_strobe_n, lower_byte_column_strobe_n, upper_byte_column_strobe_n;
  logic dq_oe, special_function_select, write_mask_enable_n, transfer_output_enable_n;
  logic serial_shift_clock, half_indicator;
  logic [8:0] addr;
  logic [15:0] dq_out, dq_in;
  int n_fail = 0;
  int cmp_count = 0;
  int c0;
  always #12.5 ref_clk = ~ref_clk;
  vram_host_ctrl u_dut (.ref_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .write_mask_enable_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .row_strobe_n, .lower_byte_column_strobe_n,
    .upper_byte_column_strobe_n, .addr, .dq_out, .dq_oe, .dq_in, .special_function_select,
    .write_mask_enable_n, .transfer_output_enable_n, .serial_shift_clock, .half_indicator);
  vram_dev_model u_dev (.row_strobe_n, .lower_byte_column_strobe_n, .upper_byte_column_strobe_n,
    .addr, .dq_out, .special_function_select, .write_mask_enable_n, .transfer_output_enable_n,
    .serial_shift_clock, .dq_in, .half_indicator);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; request held until ack is seen at an edge
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge ref_clk);
    wb_adr_i <= a;
    wb_dat_i <= d;
    write_mask_enable_i <= w;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    write_mask_enable_i <= 1'b0;
    // Acknowledge stands one cycle only
    @(posedge ref_clk);
    chk(32'(wb_ack_o), 32'h0);
  endtask : bus
  // Polls busy; leaves the last status word in rd
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(`ADR_STATUS, 32'h0, 1'b0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    if (n >= 100) chk(32'h0, 32'h1); // Busy never fell
  endtask : wait_idle
  task automatic cmd(input logic [3:0] op);
    bus(`ADR_CMD, 32'(op), 1'b1);
    wait_idle;
  endtask : cmd
  task automatic t_rw;
    bus(8'h40, 32'h0, 1'b0);
    chk(rd, 32'h0);
    bus(`ADR_ROW, 32'h123, 1'b1);
    bus(`ADR_COL, 32'h045, 1'b1);
    bus(`ADR_DATA, 32'h1234, 1'b1);
    cmd(4'd1);
    chk(u_dev.mem[{9'h123, 9'h045}], 16'h1234);
    cmd(4'd0);
    bus(`ADR_DATA, 32'h0, 1'b0);
    chk(rd[15:0], 16'h1234);
  endtask : t_rw
  // Per-cycle mask, then stored mask, then a masked block fill
  task automatic t_mask;
    bus(`ADR_MASK, 32'h00ff, 1'b1);
    bus(`ADR_DATA, 32'habcd, 1'b1);
    cmd(4'd2);
    chk(u_dev.mem[{9'h123, 9'h045}], 16'h12cd);
    bus(`ADR_DATA, 32'hff00, 1'b1);
    cmd(4'd4);
    chk(u_dev.persist, 1'b1);
    bus(`ADR_DATA, 32'h5555, 1'b1);
    cmd(4'd2);
    chk(u_dev.mem[{9'h123, 9'h045}], 16'h55cd);
    bus(`ADR_DATA, 32'h0f0f, 1'b1);
    cmd(4'd5);
    bus(`ADR_DATA, 32'h2020, 1'b1);
    cmd(4'd3);
    chk(u_dev.mem[{9'h123, 9'h045}], 16'h0fcd);
    c0 = u_dev.n_ref;
    cmd(4'd8);
    chk(u_dev.n_ref - c0, 1);
    bus(`ADR_DATA, 32'h0, 1'b0);
    chk(rd[15:0], 16'h0fcd);
  endtask : t_mask
  // Each timer refresh flavour in turn; one slot is 625 cycles
  task automatic t_refresh;
    logic [4:0] ctl [4] = '{5'h07, 5'h0b, 5'h03, 5'h01};
    logic per [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      c0 = u_dev.n_ref;
      bus(`ADR_CTRL, 32'(ctl[i]), 1'b1);
      repeat (700) @(posedge ref_clk);
      bus(`ADR_CTRL, 32'h0, 1'b1);
      repeat (12) @(posedge ref_clk);
      chk(u_dev.n_ref > c0, 1'b1);
      chk(u_dev.persist, per[i]);
      if (i == 1) chk(u_dev.stop_act, 9'h1ff);
    end
    chk(u_dev.n_stop > 0, 1'b1);
    chk(u_dev.stop_reg, 9'h1ff);
    chk(u_dev.n_rowonly > 0, 1'b1);
  endtask : t_refresh
  // Split refused before a full transfer, then full and split with the shifter running
  task automatic t_xfer;
    cmd(4'd7);
    chk(rd[2], 1'b1);
    chk(u_dev.n_split, 0);
    bus(`ADR_CTRL, 32'h10, 1'b1);
    bus(`ADR_ROW, 32'h0a0, 1'b1);
    bus(`ADR_COL, 32'h105, 1'b1);
    cmd(4'd6);
    chk(rd[3:1], 3'b101);
    chk(u_dev.xfer_row, 9'h0a0);
    bus(`ADR_COL, 32'h110, 1'b1);
    cmd(4'd7);
    chk(u_dev.tap, 8'h10);
    chk(u_dev.n_split, 1);
    repeat (1100) @(posedge ref_clk);
    bus(`ADR_STATUS, 32'h0, 1'b0);
    chk(rd[3], 1'b0);
    bus(`ADR_CTRL, 32'h0, 1'b1);
  endtask : t_xfer
  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_rw;
    t_mask;
    t_refresh;
    t_xfer;
    give_verdict;
  end
  // Watchdog: about five times the expected run
  initial begin
    #(25 * 20000);
    n_fail++;
    give_verdict;
  end
endmodule : vram_refresh_transfer_logic_tb

// *** verilog/refresh_tick_gen.sv ***
// Row refresh interval timer: one pulse per distributed refresh slot
`timescale 1ns/100ps
`include "vram_ctrl_consts.svh"
module refresh_tick_gen
  import vram_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  output logic tick
);
  tmr_t q;
  tmr_t n;

  // Counter restarts while disabled so the first slot is a full interval
  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (!enable) begin
      n.cnt = 10'h000;
    end else if (q.cnt == `ROWREF_CYC - 10'h001) begin
      n.cnt = 10'h000;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 10'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick;
endmodule : refresh_tick_gen

// *** verilog/vram_host_ctrl.sv ***
// Host controller for a dual-port video DRAM, steered over classic Wishbone
// Behaviour
// - Masked block write: function select and mask enable low at row fall, select high at column fall
// - Per-cycle mask is driven on data pins at the row strobe fall of masked writes and block writes
// - Every row refreshed within 8 ms; one row per timer slot
// - Row-only refresh strobes row address, column strobe held high
// - Hidden refresh keeps column strobe low and cycles the row strobe
// - Real-time transfer ends transfer enable with a rising shift clock while the shift clock is enabled, else when the column strobe phase ends
// - A full transfer must precede any split transfer
`timescale 1ns/100ps
`include "vram_ctrl_consts.svh"
module vram_host_ctrl
  import vram_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic write_mask_enable_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic row_strobe_n,
  output logic lower_byte_column_strobe_n,
  output logic upper_byte_column_strobe_n,
  output logic [8:0] addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in,
  output logic special_function_select,
  output logic write_mask_enable_n,
  output logic transfer_output_enable_n,
  output logic serial_shift_clock,
  input wire logic half_indicator
);
  ctl_t q;
  ctl_t n;
  op_t cur;
  logic tick;
  logic done;
  logic is_write;

  // Refresh slot pulses; at 512 slots per 8 ms every row is covered
  refresh_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(q.ctrl[`CTRL_REF_EN]),
    .tick(tick)
  );

  // A pending refresh borrows the sequencer ahead of software commands
  assign cur = q.ref_act ? (q.ctrl[`CTRL_REF_CBR] ? OP_REF_CBR : OP_REF_ROW) : q.op;
  assign done = (q.ph == `PHASE_CYC - 3'h1);
  assign is_write = (cur == OP_WRITE) || (cur == OP_MWRITE) || (cur == OP_BLOCK) ||
                    (cur == OP_LMR) || (cur == OP_LCR);

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = d[7:0];
    if (sel[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  // Whole next-state: bus slave, shift clock divider, cycle sequencer
  always_comb begin
    logic sc_rise;
    logic [15:0] t16;
    sc_rise = 1'b0;
    t16 = 16'h0000;
    n = q;
    n.ack = wb_cyc_i && wb_stb_i && !q.ack;
    n.dat_o = 32'h0000_0000;
    n.ph = done ? 3'h0 : q.ph + 3'h1;
    // Gap count restarts while refresh is off, so a re-enable never inherits an old gap
    if (!q.ctrl[`CTRL_REF_EN]) n.since_ref = 11'h000;
    else if (q.since_ref != 11'h7ff) n.since_ref = q.since_ref + 11'h001;
    // Shift clock is a divided level; the rising half is what transfers align to
    if (q.ctrl[`CTRL_SC_EN]) begin
      if (q.scdiv == `SC_HALF_CYC - 3'h1) begin
        n.scdiv = 3'h0;
        n.sc = !q.sc;
        sc_rise = !q.sc;
      end else begin
        n.scdiv = q.scdiv + 3'h1;
      end
    end
    // Bus slave: one wait-free acknowledge, unmapped addresses read zero
    if (n.ack) begin
      case (wb_adr_i)
        `ADR_CMD: begin
          n.dat_o = {28'h0000000, q.op};
          if (write_mask_enable_i && wb_sel_i[0]) begin
            // Split transfer before any full transfer is refused
            if (q.busy || (wb_dat_i[3:0] > 4'(OP_HIDDEN)) ||
                ((wb_dat_i[3:0] == 4'(OP_SRT)) && !q.full_done)) begin
              n.refused = 1'b1;
            end else begin
              n.op = op_t'(wb_dat_i[3:0]);
              n.busy = 1'b1;
              n.refused = 1'b0;
            end
          end
        end
        `ADR_STATUS: n.dat_o = {28'h0000000, half_indicator, q.refused, q.full_done, q.busy};
        `ADR_ROW: begin
          n.dat_o = {23'h000000, q.row};
          t16 = merge16({7'h00, q.row}, wb_dat_i, wb_sel_i);
          if (write_mask_enable_i) n.row = t16[8:0];
        end
        `ADR_COL: begin
          n.dat_o = {23'h000000, q.col};
          t16 = merge16({7'h00, q.col}, wb_dat_i, wb_sel_i);
          if (write_mask_enable_i) n.col = t16[8:0];
        end
        `ADR_DATA: begin
          n.dat_o = {16'h0000, q.rd_data};
          if (write_mask_enable_i) n.data = merge16(q.data, wb_dat_i, wb_sel_i);
        end
        `ADR_MASK: begin
          n.dat_o = {16'h0000, q.mask};
          if (write_mask_enable_i) n.mask = merge16(q.mask, wb_dat_i, wb_sel_i);
        end
        `ADR_CTRL: begin
          n.dat_o = {27'h0000000, q.ctrl};
          if (write_mask_enable_i && wb_sel_i[0]) n.ctrl = wb_dat_i[4:0];
        end
        default: n.dat_o = 32'h0000_0000;
      endcase
    end
    // Pin sequencer
    case (q.state)
      S_IDLE: begin
        n.ph = 3'h0;
        if (q.ctrl[`CTRL_REF_EN] && q.pend) begin
          n.pend = 1'b0;
          n.ref_act = 1'b1;
          n.state = S_SETUP;
        end else if (q.busy) begin
          n.state = S_SETUP;
        end
      end
      S_SETUP: begin
        // Pin states that classify the cycle at the row strobe fall
        n.dt_n = !((cur == OP_RT) || (cur == OP_SRT));
        n.sfs = (cur == OP_LMR) || (cur == OP_LCR) || (cur == OP_SRT) ||
                ((cur == OP_REF_CBR) && (q.ctrl[`CTRL_OPT_HI:`CTRL_OPT_LO] != `CBR_RESET));
        n.wme_n = !((cur == OP_MWRITE) || (cur == OP_BLOCK) ||
                    ((cur == OP_REF_CBR) && (q.ctrl[`CTRL_OPT_HI:`CTRL_OPT_LO] == `CBR_STOP)));
        n.cas_n = (cur != OP_REF_CBR);
        n.addr = (cur == OP_REF_ROW) ? q.ref_row : q.row;
        n.dq_out = q.mask;
        n.dq_oe = (cur == OP_MWRITE) || (cur == OP_BLOCK);
        if (done) begin
          n.state = S_RAS;
          n.ras_n = 1'b0;
        end
      end
      S_RAS: begin
        if (done) begin
          if (q.ref_act) begin
            n.since_ref = 11'h000;
            if (cur == OP_REF_ROW) n.ref_row = q.ref_row + 9'h001;
            n.state = S_PRE;
          end else begin
            // Column phase setup; block and colour load need select high
            n.state = S_COL;
            n.addr = q.col;
            n.sfs = (cur == OP_BLOCK) || (cur == OP_LCR);
            n.dq_out = q.data;
            n.dq_oe = is_write;
            if (is_write) n.wme_n = 1'b0;
            if ((cur == OP_READ) || (cur == OP_HIDDEN)) n.dt_n = 1'b0;
          end
        end
      end
      S_COL: begin
        if (done) begin
          n.state = S_CAS;
          n.cas_n = 1'b0;
        end
      end
      S_CAS: begin
        if (done) begin
          n.state = S_PRE;
          if ((cur == OP_READ) || (cur == OP_HIDDEN)) n.rd_data = dq_in;
          if (cur == OP_RT) n.full_done = 1'b1;
          if (cur == OP_HIDDEN) begin
            // Row strobe cycles while the column strobe stays low
            n.state = S_HIDE;
            n.hide_dn = 1'b0;
            n.ras_n = 1'b1;
            n.sfs = 1'b1;
            n.wme_n = 1'b1;
          end else if ((cur == OP_RT) && q.ctrl[`CTRL_SC_EN]) begin
            n.state = S_SYNC;
          end else if ((cur == OP_RT) || (cur == OP_SRT)) begin
            n.dt_n = 1'b1;
          end
        end
      end
      S_SYNC: begin
        n.ph = 3'h0;
        // Transfer enable rises with the shift clock to keep serial data continuous
        if (sc_rise) begin
          n.dt_n = 1'b1;
          n.state = S_PRE;
        end
      end
      S_HIDE: begin
        if (done) begin
          if (q.hide_dn) begin
            n.state = S_PRE;
          end else begin
            n.hide_dn = 1'b1;
            n.ras_n = 1'b0;
          end
        end
      end
      S_PRE: begin
        n.ras_n = 1'b1;
        n.cas_n = 1'b1;
        n.dq_oe = 1'b0;
        n.dt_n = 1'b1;
        n.wme_n = 1'b1;
        n.sfs = 1'b0;
        if (done) begin
          n.state = S_IDLE;
          if (q.ref_act) n.ref_act = 1'b0;
          else n.busy = 1'b0;
        end
      end
      default: n.state = S_IDLE;
    endcase
    // A slot arriving as the pending one is taken is kept
    if (tick) n.pend = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.ras_n <= 1'b1;
      q.cas_n <= 1'b1;
      q.wme_n <= 1'b1;
      q.dt_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign wb_dat_o = q.dat_o;
  assign wb_ack_o = q.ack;
  assign row_strobe_n = q.ras_n;
  assign lower_byte_column_strobe_n = q.cas_n;
  assign upper_byte_column_strobe_n = q.cas_n;
  assign addr = q.addr;
  assign dq_out = q.dq_out;
  assign dq_oe = q.dq_oe;
  assign special_function_select = q.sfs;
  assign write_mask_enable_n = q.wme_n;
  assign transfer_output_enable_n = q.dt_n;
  assign serial_shift_clock = q.sc;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_block_row;
    $fell(q.ras_n) && (cur == OP_BLOCK) |-> !q.sfs && !q.wme_n;
  endproperty
  a_block_row: assert property (p_block_row) else $error("block write row pins wrong");
  property p_block_col;
    $fell(q.cas_n) && (cur == OP_BLOCK) |-> q.sfs && !q.wme_n ##[1:4] $rose(q.cas_n);
  endproperty
  a_block_col: assert property (p_block_col) else $error("block write column pins wrong");
  property p_mask_row;
    $fell(q.ras_n) && (cur == OP_MWRITE) |-> q.dq_oe && (q.dq_out == q.mask);
  endproperty
  a_mask_row: assert property (p_mask_row) else $error("mask not driven at row fall");
  property p_refresh_gap;
    q.ctrl[`CTRL_REF_EN] |-> (q.since_ref < 11'(`ROWREF_CYC) + `REF_SLACK_CYC);
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("refresh slot overrun");
  property p_row_only;
    $fell(q.ras_n) && (cur == OP_REF_ROW) |-> q.cas_n [*3] ##1 q.ras_n;
  endproperty
  a_row_only: assert property (p_row_only) else $error("column strobe fell in row refresh");
  property p_hidden;
    $rose(q.ras_n) && (q.state == S_HIDE) |-> !q.cas_n [*3] ##0 !q.ras_n && !q.dt_n;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden refresh strobe order");
  property p_rt_sync;
    $rose(q.dt_n) && ($past(q.state) == S_SYNC) |-> $rose(q.sc) && !q.cas_n;
  endproperty
  a_rt_sync: assert property (p_rt_sync) else $error("transfer end not on shift clock");
  property p_split_order;
    // Column strobe high at the row fall: the hidden refresh counter cycle is no transfer
    $fell(q.ras_n) && q.cas_n && !q.dt_n && q.sfs |-> q.full_done;
  endproperty
  a_split_order: assert property (p_split_order) else $error("split before full transfer");

  c_split: cover property ($fell(q.ras_n) && (cur == OP_SRT));
  c_hidden: cover property ($fell(q.ras_n) && (q.state == S_HIDE));
  c_refresh: cover property ($fell(q.ras_n) && q.ref_act);
  c_rt_sync: cover property ($past(q.state) == S_SYNC && $rose(q.dt_n));
endmodule : vram_host_ctrl
